// *** lbert_defs.svh ***
// Constants of the line bit error rate tester: fields, thresholds, saturation values
`ifndef LBERT_DEFS_SVH
`define LBERT_DEFS_SVH

// Pattern buffer shape
`define LBERT_FIFO_DEPTH 16
`define LBERT_FIFO_WIDTH 1

// Sync hunt: matching run that declares sync (last count of the run)
`define LBERT_SYNC_LAST 6'h1F
// Sync loss: window length (last count) and error count that drops sync
`define LBERT_LOSS_WIN_LAST 6'h3F
`define LBERT_LOSS_ERRS 4'h6

// Saturation values of the two counters
`define LBERT_BITCNT_MAX 32'hFFFF_FFFF
`define LBERT_ERRCNT_MAX 24'hFF_FFFF

// Daly stress sequence, 64 bits sent from bit 0 upward
`define LBERT_DALY_SEQ 64'h8000_0180_FF00_7E01

// Bit positions in the event information word
`define LBERT_EV_SYNC 0
`define LBERT_EV_ERR 1
`define LBERT_EV_OVF 2

// Bit positions in transceiver status nine
`define LBERT_ST_SYNC 0
`define LBERT_ST_ERR 1
`define LBERT_ST_BCO 2
`define LBERT_ST_ECO 3

`endif

// *** lbert_fifo.sv ***
// Small synchronous FIFO holding generated pattern bits
`timescale 1ns/1ps
`default_nettype none
module lbert_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 16
) (
  input wire logic clock,      // Core clock
  input wire logic sys_rst,    // Synchronous reset
  lbert_fifo_if.store port     // Write and read handshakes
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [AW:0] level_r;
  logic doWr;
  logic doRd;

  // Honest flags from the fill level
  assign port.wrReady = (level_r != DEPTH[AW:0]);
  assign port.rdValid = (level_r != '0);
  assign port.rdData = mem[rdPtr_r];
  assign doWr = port.wrValid & port.wrReady;
  assign doRd = port.rdValid & port.rdReady;

  // Storage array
  always_ff @(posedge clock) begin
    if (doWr) begin
      mem[wrPtr_r] <= port.wrData;
    end
  end

  // Pointers and level, flush empties
  always_ff @(posedge clock) begin
    if (sys_rst || port.flush) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      level_r <= '0;
    end else begin
      if (doWr) begin
        wrPtr_r <= (wrPtr_r == AW'(DEPTH - 1)) ? '0 : wrPtr_r + 1'b1;
      end
      if (doRd) begin
        rdPtr_r <= (rdPtr_r == AW'(DEPTH - 1)) ? '0 : rdPtr_r + 1'b1;
      end
      level_r <= level_r + (AW+1)'(doWr) - (AW+1)'(doRd);
    end
  end
endmodule
`default_nettype wire

// *** lbert_fifo_if.sv ***
// Handshake bundle between the pattern source and its buffer
`timescale 1ns/1ps
`default_nettype none
interface lbert_fifo_if #(parameter int WIDTH = 1);
  logic [WIDTH-1:0] wrData;
  logic wrValid;
  logic wrReady;
  logic [WIDTH-1:0] rdData;
  logic rdValid;
  logic rdReady;
  logic flush;
  modport store (input wrData, wrValid, rdReady, flush, output wrReady, rdData, rdValid);
  modport user (output wrData, wrValid, rdReady, flush, input wrReady, rdData, rdValid);
endinterface
`default_nettype wire

// *** lbert_framer_model.sv ***
// Framer datapath model that loops generated transmit bits back as receive bits
`timescale 1ns/1ps
`default_nettype none
module lbert_framer_model (
  input wire logic clock,      // Core clock
  input wire logic sys_rst,    // Synchronous reset
  input wire logic flip,       // Invert looped bits while high
  input wire logic txBitEnOut, // Tester transmit strobe
  input wire logic txDataOut,  // Tester transmit bit
  output logic txBitEn,        // Transmit stream strobe
  output logic txDataIn,       // Transmit stream bit
  output logic rxBitEn,        // Receive stream strobe
  output logic rxDataIn        // Receive stream bit
);
  logic [3:0] seq;
  initial begin
    seq = 4'h0;
    txBitEn = 1'b0;
    txDataIn = 1'b0;
    rxBitEn = 1'b0;
    rxDataIn = 1'b0;
  end
  // Strobe every other cycle; between strobes the data lines show the inverse
  always @(negedge clock) begin
    if (sys_rst) begin
      txBitEn <= 1'b0;
      rxBitEn <= 1'b0;
      seq <= 4'h0;
    end else begin
      txBitEn <= ~txBitEn;
      seq <= seq + 4'h1;
      txDataIn <= txBitEn ? ~txDataIn : seq[1];
      rxBitEn <= txBitEnOut;
      rxDataIn <= txBitEnOut ? (txDataOut ^ flip) : ~rxDataIn;
    end
  end
endmodule
`default_nettype wire

// *** lbert_pat.sv ***
// Pattern engine shared by the generator and the receive reference
`timescale 1ns/1ps
`default_nettype none
`include "lbert_defs.svh"
module lbert_pat (
  input wire logic clock,                 // Core clock
  input wire logic sys_rst,               // Synchronous reset
  input wire logic restart,               // Reload from pattern word
  input wire logic advance,               // Step one bit
  input wire logic seed,                  // Shift in seedBit instead of feedback
  input wire logic seedBit,               // Received bit for self seeding
  input wire lbert_pkg::lbert_mode_t mode, // Pattern selection
  input wire logic [31:0] pattern,        // Four pattern bytes
  input wire logic [7:0] altCount,        // Word repeats, zero means 256
  output logic patBit                     // Current pattern bit
);
  logic [19:0] sr_r;
  logic [5:0] idx_r;
  logic [7:0] rep_r;
  logic word_r;
  logic fb;
  logic [63:0] dalySeq;

  assign dalySeq = `LBERT_DALY_SEQ;

  // Feedback taps and output bit per mode
  always_comb begin
    fb = 1'b1;
    patBit = 1'b1;
    case (mode)
      lbert_pkg::LBERT_PRBS7: begin fb = sr_r[6] ^ sr_r[5]; patBit = fb; end
      lbert_pkg::LBERT_PRBS11: begin fb = sr_r[10] ^ sr_r[8]; patBit = fb; end
      lbert_pkg::LBERT_PRBS15: begin fb = sr_r[14] ^ sr_r[13]; patBit = fb; end
      lbert_pkg::LBERT_QRSS: begin
        fb = sr_r[19] ^ sr_r[16];
        patBit = fb | (sr_r[13:0] == 14'h0000);
      end
      lbert_pkg::LBERT_REPEAT: patBit = pattern[idx_r[4:0]];
      lbert_pkg::LBERT_ALTWORD: patBit = word_r ? pattern[{1'b1, idx_r[3:0]}]
                                                : pattern[{1'b0, idx_r[3:0]}];
      lbert_pkg::LBERT_DALY: patBit = dalySeq[idx_r];
      default: patBit = 1'b1;
    endcase
  end

  // Shift register and position counters
  always_ff @(posedge clock) begin
    if (sys_rst || restart) begin
      sr_r <= pattern[19:0];
      idx_r <= '0;
      rep_r <= '0;
      word_r <= 1'b0;
    end else if (advance) begin
      sr_r <= {sr_r[18:0], seed ? seedBit : fb};
      case (mode)
        lbert_pkg::LBERT_REPEAT: idx_r <= {1'b0, idx_r[4:0] + 5'h01};
        lbert_pkg::LBERT_DALY: idx_r <= idx_r + 6'h01;
        lbert_pkg::LBERT_ALTWORD: begin
          idx_r <= {2'b00, idx_r[3:0] + 4'h1};
          if (idx_r[3:0] == 4'hF) begin
            if (rep_r == altCount - 8'h01) begin
              rep_r <= '0;
              word_r <= ~word_r;
            end else begin
              rep_r <= rep_r + 8'h01;
            end
          end
        end
        default: idx_r <= idx_r;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** lbert_pkg.sv ***
// Types shared by the line bit error rate tester modules
package lbert_pkg;

  // Pattern selection
  typedef enum logic [2:0] {
    LBERT_PRBS7 = 3'b000,
    LBERT_PRBS11 = 3'b001,
    LBERT_PRBS15 = 3'b010,
    LBERT_QRSS = 3'b011,
    LBERT_REPEAT = 3'b100,
    LBERT_ALTWORD = 3'b101,
    LBERT_DALY = 3'b110
  } lbert_mode_t;

  // Receive synchroniser state
  typedef enum logic {
    LBERT_HUNT = 1'b0,
    LBERT_LOCKED = 1'b1
  } lbert_sync_t;

endpackage

// *** lbert_tester.sv ***
// Line bit error rate tester: pattern insertion, checking, counters, events
`timescale 1ns/1ps
`default_nettype none
`include "lbert_defs.svh"
// Notes on behaviour
// - Generate and check PRBS7/11/15, QRSS, Daly
// - Repeating user pattern, always all 32 bits
// - Two 16-bit words alternate every 1..256 repeats
// - 32-bit bit counter, 24-bit error counter
// - Events: sync change, bit error, overflow
// - Each event has its own mask bit
// - Info register records events; host reads it
// - Tester idle until mux selection enables it
// - Status nine flags every major change
// - Direction bit picks network or backplane side
// - Per-slot flags restrict insertion and checking
// - T1 framing bit optionally tested per direction
// - 32-bit pattern sent bit zero first
// - Alternating words: bytes 0-1 then 2-3
// - Bit counter counts every checked bit in sync
// - Error counter counts mismatches in sync
// - Load-counters toggle clears both counters
// - Bit counter saturates and flags overflow
// - Error counter saturates and flags overflow
// - Each word repeats word-count times, then switches
// - Latched status clears on host read
module lbert_tester (
  input wire logic clock,                   // Core clock, 100 MHz
  input wire logic sys_rst,                 // Synchronous reset, active high
  input wire logic muxEnable,               // Tester routed into datapath
  input wire logic dirBackplane,            // Interface control bit 1: backplane side
  input wire logic t1Mode,                  // Framer in T1 mode
  input wire logic txFramingBitInclude,     // Test F-bit in transmit stream
  input wire logic rxFramingBitInclude,     // Test F-bit in receive stream
  input wire lbert_pkg::lbert_mode_t mode,  // Pattern selection
  input wire logic [7:0] patternByte0,      // Pattern bits 7:0
  input wire logic [7:0] patternByte1,      // Pattern bits 15:8
  input wire logic [7:0] patternByte2,      // Pattern bits 23:16
  input wire logic [7:0] patternByte3,      // Pattern bits 31:24
  input wire logic [7:0] alternatingWordCount, // Word repeats, zero means 256
  input wire logic [2:0] eventMask,         // Control one: 1 masks an event
  input wire logic loadCounters,            // Control one: rising edge clears counters
  input wire logic eventInfoRead,           // Host reads event info, pulse
  input wire logic statusRead,              // Host reads status nine, pulse
  input wire logic txBitEn,                 // Transmit stream bit strobe
  input wire logic txDataIn,                // Transmit stream bit in
  input wire logic txSlotTestSelect,        // Current transmit slot selected
  input wire logic txFbit,                  // Current transmit bit is the F-bit
  input wire logic rxBitEn,                 // Receive stream bit strobe
  input wire logic rxDataIn,                // Receive stream bit in
  input wire logic rxSlotTestSelect,        // Current receive slot selected
  input wire logic rxFbit,                  // Current receive bit is the F-bit
  output logic txBitEnOut,                  // Transmit stream strobe out
  output logic txDataOut,                   // Transmit stream bit out
  output logic rxBitEnOut,                  // Receive stream strobe out
  output logic rxDataOut,                   // Receive stream bit out
  output logic [31:0] bitCount,             // Checked bits
  output logic [23:0] errorCount,           // Errored bits
  output logic [2:0] testerEventInfo,       // Latched unmasked events
  output logic [3:0] transceiverStatusNine, // Latched state changes
  output logic syncLive,                    // Checker in sync
  output logic alert                        // Unmasked event pending
);
  logic [31:0] pattern;
  logic txTested;
  logic rxTested;
  logic genStep;
  logic genBit;
  logic chkStep;
  logic chkData;
  logic refBit;
  logic engBit;
  logic isPrbs;
  logic restart;
  logic lcRise;
  logic mismatch;
  logic [2:0] ev;
  logic evBco;
  logic evEco;
  logic [2:0] infoNxt;
  lbert_pkg::lbert_mode_t mode_r;
  lbert_pkg::lbert_sync_t sync_r;
  lbert_pkg::lbert_sync_t sync_nxt;
  logic muxEn_r;
  logic lc_r;
  logic [5:0] run_r;
  logic [5:0] win_r;
  logic [3:0] winErr_r;
  logic [31:0] bitCount_r;
  logic [23:0] errorCount_r;
  logic [2:0] info_r;
  logic [3:0] status_r;
  logic alert_r;
  logic txBitEn_r;
  logic txData_r;
  logic rxBitEn_r;
  logic rxData_r;

  lbert_fifo_if #(.WIDTH(`LBERT_FIFO_WIDTH)) patQ ();

  // bytes form one word, bit 0 first
  assign pattern = {patternByte3, patternByte2, patternByte1, patternByte0};
  assign isPrbs = (mode == lbert_pkg::LBERT_PRBS7) || (mode == lbert_pkg::LBERT_PRBS11) ||
                  (mode == lbert_pkg::LBERT_PRBS15) || (mode == lbert_pkg::LBERT_QRSS);
  assign restart = (muxEnable & ~muxEn_r) | (mode != mode_r);
  assign lcRise = loadCounters & ~lc_r;

  // slot flags select bits; F-bit only in T1 when enabled; idle until routed
  assign txTested = muxEnable & (txFbit ? (t1Mode & txFramingBitInclude) : txSlotTestSelect);
  assign rxTested = muxEnable & (rxFbit ? (t1Mode & rxFramingBitInclude) : rxSlotTestSelect);

  // direction swaps which stream is generated and which is checked
  assign genStep = dirBackplane ? (rxBitEn & rxTested) : (txBitEn & txTested);
  assign chkStep = dirBackplane ? (txBitEn & txTested) : (rxBitEn & rxTested);
  assign chkData = dirBackplane ? txDataIn : rxDataIn;
  assign genBit = patQ.rdValid ? patQ.rdData[0] : 1'b1;

  // Edge detectors for enable, mode and counter load
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      muxEn_r <= 1'b0;
      mode_r <= lbert_pkg::LBERT_PRBS7;
      lc_r <= 1'b0;
    end else begin
      muxEn_r <= muxEnable;
      mode_r <= mode;
      lc_r <= loadCounters;
    end
  end

  // generator engine, stalled by the buffer when full
  lbert_pat genEng (
    .clock(clock),
    .sys_rst(sys_rst),
    .restart(restart),
    .advance(patQ.wrValid & patQ.wrReady),
    .seed(1'b0),
    .seedBit(1'b0),
    .mode(mode),
    .pattern(pattern),
    .altCount(alternatingWordCount),
    .patBit(engBit)
  );

  // Buffer feeding generated bits to the inserted stream
  assign patQ.wrData = engBit;
  assign patQ.wrValid = muxEnable;
  assign patQ.rdReady = genStep;
  assign patQ.flush = restart | ~muxEnable;

  lbert_fifo #(.WIDTH(`LBERT_FIFO_WIDTH), .DEPTH(`LBERT_FIFO_DEPTH)) patFifo (
    .clock(clock),
    .sys_rst(sys_rst),
    .port(patQ)
  );

  // PRBS reference seeds from received bits while hunting
  lbert_pat refEng (
    .clock(clock),
    .sys_rst(sys_rst),
    .restart(restart),
    .advance(chkStep & (isPrbs | (sync_r == lbert_pkg::LBERT_LOCKED) | ~mismatch)),
    .seed(isPrbs & (sync_r == lbert_pkg::LBERT_HUNT)),
    .seedBit(chkData),
    .mode(mode),
    .pattern(pattern),
    .altCount(alternatingWordCount),
    .patBit(refBit)
  );

  assign mismatch = chkData ^ refBit;

  // untested bits pass through; insertion on the chosen side
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      txBitEn_r <= 1'b0;
      txData_r <= 1'b1;
      rxBitEn_r <= 1'b0;
      rxData_r <= 1'b1;
    end else begin
      txBitEn_r <= txBitEn;
      rxBitEn_r <= rxBitEn;
      if (txBitEn) begin
        txData_r <= (~dirBackplane & txTested) ? genBit : txDataIn;
      end
      if (rxBitEn) begin
        rxData_r <= (dirBackplane & rxTested) ? genBit : rxDataIn;
      end
    end
  end

  always_comb begin
    sync_nxt = sync_r;
    case (sync_r)
      lbert_pkg::LBERT_HUNT: begin
        if (chkStep && !mismatch && run_r == `LBERT_SYNC_LAST) begin
          sync_nxt = lbert_pkg::LBERT_LOCKED;
        end
      end
      lbert_pkg::LBERT_LOCKED: begin
        if (chkStep && mismatch && winErr_r == `LBERT_LOSS_ERRS - 4'h1) begin
          sync_nxt = lbert_pkg::LBERT_HUNT;
        end
      end
      default: sync_nxt = lbert_pkg::LBERT_HUNT;
    endcase
  end

  // sync state, matching run and error window
  always_ff @(posedge clock) begin
    if (sys_rst || restart || !muxEnable) begin
      sync_r <= lbert_pkg::LBERT_HUNT;
      run_r <= '0;
      win_r <= '0;
      winErr_r <= '0;
    end else if (chkStep) begin
      sync_r <= sync_nxt;
      run_r <= (mismatch || sync_r == lbert_pkg::LBERT_LOCKED) ? 6'h00 : run_r + 6'h01;
      if (sync_r == lbert_pkg::LBERT_HUNT || win_r == `LBERT_LOSS_WIN_LAST) begin
        win_r <= '0;
        winErr_r <= '0;
      end else begin
        win_r <= win_r + 6'h01;
        winErr_r <= winErr_r + {3'b000, mismatch};
      end
    end
  end

  // bit counter, saturating; cleared by load toggle
  always_ff @(posedge clock) begin
    if (sys_rst || lcRise) begin
      bitCount_r <= '0;
    end else if (chkStep && sync_r == lbert_pkg::LBERT_LOCKED &&
                 bitCount_r != `LBERT_BITCNT_MAX) begin
      bitCount_r <= bitCount_r + 32'h0000_0001;
    end
  end

  // error counter, saturating; cleared by load toggle
  always_ff @(posedge clock) begin
    if (sys_rst || lcRise) begin
      errorCount_r <= '0;
    end else if (chkStep && mismatch && sync_r == lbert_pkg::LBERT_LOCKED &&
                 errorCount_r != `LBERT_ERRCNT_MAX) begin
      errorCount_r <= errorCount_r + 24'h00_0001;
    end
  end

  // event pulses, overflow when a counter reaches its maximum
  assign evBco = ~lcRise & chkStep & (sync_r == lbert_pkg::LBERT_LOCKED) &
                 (bitCount_r == `LBERT_BITCNT_MAX - 32'h0000_0001);
  assign evEco = ~lcRise & chkStep & mismatch & (sync_r == lbert_pkg::LBERT_LOCKED) &
                 (errorCount_r == `LBERT_ERRCNT_MAX - 24'h00_0001);
  assign ev[`LBERT_EV_SYNC] = ~sys_rst & ~restart & muxEnable & chkStep & (sync_nxt != sync_r);
  assign ev[`LBERT_EV_ERR] = chkStep & mismatch & (sync_r == lbert_pkg::LBERT_LOCKED);
  assign ev[`LBERT_EV_OVF] = evBco | evEco;

  // mask gates recording; read clears, a new event wins
  assign infoNxt = ({3{~eventInfoRead}} & info_r) | (ev & ~eventMask);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      info_r <= '0;
      alert_r <= 1'b0;
    end else begin
      info_r <= infoNxt;
      alert_r <= |infoNxt;
    end
  end

  // status nine latches every major change, read clears
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      status_r <= '0;
    end else begin
      status_r <= ({4{~statusRead}} & status_r) |
                  {evEco, evBco, ev[`LBERT_EV_ERR], ev[`LBERT_EV_SYNC]};
    end
  end

  // Outputs straight from flops
  assign txBitEnOut = txBitEn_r;
  assign txDataOut = txData_r;
  assign rxBitEnOut = rxBitEn_r;
  assign rxDataOut = rxData_r;
  assign bitCount = bitCount_r;
  assign errorCount = errorCount_r;
  assign testerEventInfo = info_r;
  assign transceiverStatusNine = status_r;
  assign syncLive = sync_r;
  assign alert = alert_r;

  // Checks on the tester's own behaviour
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  bitcnt_saturate_a: assert property (
    (bitCount_r == `LBERT_BITCNT_MAX) && !lcRise |=> bitCount_r == `LBERT_BITCNT_MAX)
    else $error("bit counter left its maximum");

  bitcnt_step_a: assert property (
    chkStep && sync_r == lbert_pkg::LBERT_LOCKED && !lcRise &&
    bitCount_r != `LBERT_BITCNT_MAX |=> bitCount_r == $past(bitCount_r) + 32'h0000_0001)
    else $error("bit counter missed a locked bit");

  errcnt_step_a: assert property (
    chkStep && !mismatch && !lcRise |=> errorCount_r == $past(errorCount_r))
    else $error("error counter moved on a good bit");

  counter_clear_a: assert property (
    loadCounters && !lc_r |=> bitCount_r == 32'h0000_0000 && errorCount_r == 24'h00_0000)
    else $error("load toggle did not clear counters");

  info_masked_a: assert property (
    (eventMask[`LBERT_EV_ERR] && !info_r[`LBERT_EV_ERR]) |=> !info_r[`LBERT_EV_ERR])
    else $error("masked error was recorded");

  alert_tracks_a: assert property (
    alert_r == |info_r)
    else $error("alert disagrees with event info");

  idle_pass_a: assert property (
    !muxEnable && txBitEn |=> txDataOut == $past(txDataIn) && txBitEnOut)
    else $error("idle tester altered the transmit stream");

  sync_gain_a: assert property (
    $rose(sync_r) |-> $past(run_r) == `LBERT_SYNC_LAST && $past(chkStep))
    else $error("sync declared without a full clean run");

  status_error_a: assert property (
    ev[`LBERT_EV_ERR] |=> status_r[`LBERT_ST_ERR] &&
    (info_r[`LBERT_EV_ERR] || $past(eventMask[`LBERT_EV_ERR])))
    else $error("bit error not latched");

  sync_seen_c: cover property ($rose(sync_r));
  error_seen_c: cover property (ev[`LBERT_EV_ERR] ##1 alert_r);
  sync_loss_c: cover property ($fell(sync_r));
  fifo_full_c: cover property (muxEnable && !patQ.wrReady);

endmodule
`default_nettype wire

// *** lbert_tester_tb.sv ***
// Self-checking testbench for the line bit error rate tester
`timescale 1ns/1ps
`default_nettype none
module lbert_tester_tb;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic muxEnable = 1'b0, flip = 1'b0, loadCounters = 1'b0, dirBackplane = 1'b0;
  logic eventInfoRead = 1'b0, statusRead = 1'b0, txSel = 1'b1, passChk = 1'b0, lastTx = 1'b0;
  logic [2:0] eventMask = 3'h0;
  logic rxSel = 1'b1;
  logic [7:0] altCnt = 8'h02;
  logic [31:0] pat = 32'hFFFF_FFFF;
  lbert_pkg::lbert_mode_t mode = lbert_pkg::LBERT_PRBS7;
  logic txBitEn, txDataIn, rxBitEn, rxDataIn, txBitEnOut, txDataOut, rxBitEnOut, rxDataOut;
  logic syncLive, alert;
  logic [31:0] bitCount, b0;
  logic [23:0] errorCount;
  logic [2:0] testerEventInfo;
  logic [3:0] transceiverStatusNine;
  int n_mismatch = 0, samples_checked = 0, k;

  // Free-running 100 MHz clock
  always #5 clock = ~clock;

  lbert_tester u_lbert_tester (.clock(clock), .sys_rst(sys_rst), .muxEnable(muxEnable),
    .dirBackplane(dirBackplane), .t1Mode(1'b0), .txFramingBitInclude(1'b0),
    .rxFramingBitInclude(1'b0), .mode(mode), .patternByte0(pat[7:0]),
    .patternByte1(pat[15:8]), .patternByte2(pat[23:16]), .patternByte3(pat[31:24]),
    .alternatingWordCount(altCnt), .eventMask(eventMask), .loadCounters(loadCounters),
    .eventInfoRead(eventInfoRead), .statusRead(statusRead), .txBitEn(txBitEn),
    .txDataIn(txDataIn), .txSlotTestSelect(txSel), .txFbit(1'b0), .rxBitEn(rxBitEn),
    .rxDataIn(rxDataIn), .rxSlotTestSelect(rxSel), .rxFbit(1'b0), .txBitEnOut(txBitEnOut),
    .txDataOut(txDataOut), .rxBitEnOut(rxBitEnOut), .rxDataOut(rxDataOut),
    .bitCount(bitCount), .errorCount(errorCount), .testerEventInfo(testerEventInfo),
    .transceiverStatusNine(transceiverStatusNine), .syncLive(syncLive), .alert(alert));

  lbert_framer_model u_lbert_framer_model (.clock(clock), .sys_rst(sys_rst), .flip(flip),
    .txBitEnOut(txBitEnOut), .txDataOut(txDataOut), .txBitEn(txBitEn), .txDataIn(txDataIn),
    .rxBitEn(rxBitEn), .rxDataIn(rxDataIn));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("Comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Bounded wait for the checker to reach a sync state
  task automatic wait_sync(input logic exp);
    int i;
    for (i = 0; i < 3000 && syncLive !== exp; i++) @(negedge clock);
    if (syncLive !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t sync wait timed out", $time);
      test_done();
    end
  endtask

  // Host read pulse on event info or status nine
  task automatic host_read(input logic info);
    @(negedge clock);
    if (info) eventInfoRead = 1'b1;
    else statusRead = 1'b1;
    @(negedge clock);
    eventInfoRead = 1'b0;
    statusRead = 1'b0;
  endtask

  // Corrupt exactly one looped-back bit
  task automatic inject;
    @(negedge clock);
    flip <= 1'b1;
    repeat (2) @(negedge clock);
    flip <= 1'b0;
    repeat (6) @(negedge clock);
  endtask

  // Untested bits must leave the tester as they came in, one cycle later
  always @(posedge clock) if (txBitEn) lastTx <= txDataIn;
  always @(negedge clock) if (passChk && txBitEnOut) check(txDataOut, lastTx);

  initial begin
    repeat (2) @(negedge clock);
    sys_rst <= 1'b0;
    @(negedge clock);
    check(txDataOut, 1'b1);
    check(bitCount, 32'h0000_0000);
    check(transceiverStatusNine, 4'h0);
    // Tester idle, then enabled with the transmit slot deselected
    passChk = 1'b1;
    repeat (20) @(negedge clock);
    check(syncLive, 1'b0);
    mode = lbert_pkg::LBERT_REPEAT;
    txSel = 1'b0;
    muxEnable = 1'b1;
    repeat (20) @(negedge clock);
    check(syncLive, 1'b0);
    passChk = 1'b0;
    muxEnable = 1'b0;
    txSel = 1'b1;
    repeat (4) @(negedge clock);
    // Every pattern kind syncs over the loopback
    for (k = 0; k < 7; k++) begin
      mode = lbert_pkg::lbert_mode_t'(k[2:0]);
      // words: repeating five-bit pattern, all ones, alternating words
      pat = (k == 4) ? 32'h5AD6_B5AD : (k == 5) ? 32'h7E7E_0000 : 32'hFFFF_FFFF;
      host_read(1'b0);
      host_read(1'b1);
      muxEnable = 1'b1;
      wait_sync(1'b1);
      repeat (200) @(negedge clock);
      check(syncLive, 1'b1);
      check(transceiverStatusNine, 4'h1);
      check(testerEventInfo, 3'h1);
      check(alert, 1'b1);
      host_read(1'b0);
      host_read(1'b1);
      check(transceiverStatusNine, 4'h0);
      check(alert, 1'b0);
      muxEnable = 1'b0;
      repeat (4) @(negedge clock);
    end
    // Counting and masked errors in the Daly pattern
    muxEnable = 1'b1;
    wait_sync(1'b1);
    eventMask = 3'h2;
    @(negedge clock);
    loadCounters = 1'b1;
    @(negedge clock);
    loadCounters = 1'b0;
    host_read(1'b0);
    host_read(1'b1);
    check(errorCount, 24'h00_0000);
    b0 = bitCount;
    k = 0;
    repeat (20) @(posedge clock) if (rxBitEn) k++;
    @(negedge clock);
    check(bitCount, b0 + k);
    inject();
    check(errorCount, 24'h00_0001);
    check(transceiverStatusNine[1], 1'b1);
    check(testerEventInfo[1], 1'b0);
    eventMask = 3'h0;
    inject();
    check(errorCount, 24'h00_0002);
    check(testerEventInfo[1], 1'b1);
    host_read(1'b1);
    check(alert, 1'b0);
    // A burst of errors drops sync
    host_read(1'b0);
    flip <= 1'b1;
    wait_sync(1'b0);
    flip <= 1'b0;
    check(transceiverStatusNine[0], 1'b1);
    // Backplane side checks the transmit stream, which carries no pattern
    muxEnable = 1'b0;
    dirBackplane = 1'b1;
    repeat (4) @(negedge clock);
    muxEnable = 1'b1;
    repeat (300) @(negedge clock);
    check(syncLive, 1'b0);
    test_done();
  end
endmodule
`default_nettype wire
